/* File: verilog/hppc_pkg.sv */
// Purpose: Shared constants and types for the host parallel port block
// Assumes: 250 MHz core clock, 8-bit host bus, 16-bit software port
// Notes:   Host register indices follow the classic UART layout
package hppc_pkg;
    localparam int HOST_DATA_W = 8;
    localparam int SW_DATA_W = 16;
    localparam int SW_ADDR_W = 4;
    localparam int EV_W = 4;

    // Host register indices (three address lines)
    localparam logic [2:0] HOST_IDX_DATA = 3'h0;
    localparam logic [2:0] HOST_IDX_INT_EN = 3'h1;
    localparam logic [2:0] HOST_IDX_INT_ID = 3'h2;
    localparam logic [2:0] HOST_IDX_LINE_CTRL = 3'h3;
    localparam logic [2:0] HOST_IDX_MODEM_CTRL = 3'h4;
    localparam logic [2:0] HOST_IDX_LINE_STAT = 3'h5;
    localparam logic [2:0] HOST_IDX_MODEM_STAT = 3'h6;
    localparam logic [2:0] HOST_IDX_SCRATCH = 3'h7;

    // Field positions
    localparam int LCR_DIV_ACCESS_BIT = 7;
    localparam int IEN_RX = 0;
    localparam int IEN_THRE = 1;
    localparam int IEN_ERR = 2;
    localparam int IEN_MS = 3;
    localparam int LS_READY = 0;
    localparam int LS_ERR_LSB = 1;
    localparam int LS_THR_EMPTY = 5;
    localparam int LS_TX_IDLE = 6;
    localparam int EV_TX_WRITE = 0;
    localparam int EV_RX_READ = 1;
    localparam int EV_CFG_WRITE = 2;
    localparam int EV_READY = 3;

    // Interrupt identification codes, highest priority first
    localparam logic [3:0] INT_ID_ERR = 4'h6;
    localparam logic [3:0] INT_ID_RX = 4'h4;
    localparam logic [3:0] INT_ID_THRE = 4'h2;
    localparam logic [3:0] INT_ID_MS = 4'h0;
    localparam logic [3:0] INT_ID_NONE = 4'h1;

    // Reset values
    localparam logic [15:0] DIVISOR_DEFAULT = 16'h000c;
    localparam logic [7:0] LINE_CTRL_RESET = 8'h03;
    localparam logic [14:0] PIN_IDLE = 15'h7800;

    // Software port word addresses
    localparam logic [3:0] SW_RX_DATA = 4'h0;
    localparam logic [3:0] SW_TX_DATA = 4'h1;
    localparam logic [3:0] SW_LINE_ERR = 4'h2;
    localparam logic [3:0] SW_MODEM_STAT = 4'h3;
    localparam logic [3:0] SW_HOST_CFG = 4'h4;
    localparam logic [3:0] SW_DIVISOR = 4'h5;
    localparam logic [3:0] SW_IRQ_STATUS = 4'h6;
    localparam logic [3:0] SW_IRQ_CLEAR = 4'h7;
    localparam logic [3:0] SW_IRQ_ENABLE = 4'h8;
    localparam logic [3:0] SW_PORT_STATUS = 4'h9;

    // Start-up delay
    localparam longint unsigned CLOCK_HZ = 64'd250_000_000;
    localparam longint unsigned READY_TIME_S = 64'd6;
    localparam longint unsigned READY_CYCLES = READY_TIME_S * CLOCK_HZ;

    typedef enum logic [1:0] {
        PORT_BOOT,
        PORT_IDLE,
        PORT_READ,
        PORT_WRITE
    } hppc_state_type;

    typedef enum logic [3:0] {
        T_DATA, T_DIV_LO, T_DIV_HI, T_INT_EN, T_INT_ID,
        T_LINE_CTRL, T_MODEM_CTRL, T_LINE_STAT, T_MODEM_STAT, T_SCRATCH
    } hppc_target_type;

    function automatic hppc_target_type hppc_decode(
        input logic [2:0] idx,
        input logic div_access
    );
        hppc_target_type t;
        t = T_SCRATCH;
        if (idx == HOST_IDX_DATA) begin
            t = div_access ? T_DIV_LO : T_DATA;
        end else if (idx == HOST_IDX_INT_EN) begin
            t = div_access ? T_DIV_HI : T_INT_EN;
        end else if (idx == HOST_IDX_INT_ID) begin
            t = T_INT_ID;
        end else if (idx == HOST_IDX_LINE_CTRL) begin
            t = T_LINE_CTRL;
        end else if (idx == HOST_IDX_MODEM_CTRL) begin
            t = T_MODEM_CTRL;
        end else if (idx == HOST_IDX_LINE_STAT) begin
            t = T_LINE_STAT;
        end else if (idx == HOST_IDX_MODEM_STAT) begin
            t = T_MODEM_STAT;
        end
        return t;
    endfunction
endpackage

/* File: verilog/hppc_sync.sv */
// Purpose: Two-stage synchroniser for asynchronous host pins
// Assumes: Synchronous active-high reset, constant reset value
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module hppc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    always_ff @(posedge clock) begin
        if (reset) begin
            stage1_reg <= RESET_VALUE;
            stage2_reg <= RESET_VALUE;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;
endmodule
`default_nettype wire

/* File: verilog/hppc_port.sv */
// Purpose: Device end of an 8-bit asynchronous host port with UART map
// Assumes: Host strobes asynchronous to clock, 40 ns minimum pulses
// Notes:   Reset pin clears host side; software events are kept
// Contract
// - Reset pin clears logic, reloads stored configuration
// - Accept host commands only after start-up delay
// - Address lines pick target register per access
// - Divisor access bit redirects some addresses
// - Interrupt high on any enabled active source
// - Interrupt drops on matching service or reset
// - Write needs select low and write strobe
// - Strobes ignored unless device select low
// - Read drives addressed register onto bus
// - Third address line joins register selection
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module hppc_port #(
    parameter logic [31:0] READY_CYCLES_P = 32'(hppc_pkg::READY_CYCLES)
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic reset_pin_n,
    input wire logic device_select_n,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic host_addr_bit0,
    input wire logic host_addr_bit1,
    input wire logic host_addr_bit2,
    input wire logic [hppc_pkg::HOST_DATA_W-1:0] host_data_in,
    output logic [hppc_pkg::HOST_DATA_W-1:0] host_data_out,
    output logic host_data_oe,
    output logic host_int,
    output logic ready_for_commands,
    input wire logic nonvolatile_store_valid,
    input wire logic [15:0] nonvolatile_store_divisor,
    input wire logic [hppc_pkg::SW_ADDR_W-1:0] sw_addr,
    input wire logic [hppc_pkg::SW_DATA_W-1:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [hppc_pkg::SW_DATA_W-1:0] sw_rdata,
    output logic sw_irq
);
    import hppc_pkg::*;

    logic [14:0] pins_sync;
    logic rst_pin_n_s, sel_n_s, rd_n_s, wr_n_s;
    logic [2:0] addr_s;
    logic [7:0] data_s;
    logic master_reset, sel_rd, sel_wr, write_commit, read_done;
    hppc_state_type state_reg;
    logic [31:0] boot_count_reg;
    logic [2:0] acc_addr_reg;
    logic [7:0] wr_data_reg;
    hppc_target_type acc_target;
    logic [7:0] rx_hold_reg, tx_hold_reg, scratch_reg, fifo_ctrl_reg;
    logic [7:0] line_ctrl_reg;
    logic [4:0] modem_ctrl_reg;
    logic [3:0] int_en_reg, modem_stat_reg, modem_delta_reg;
    logic [2:0] rx_err_reg;
    logic [15:0] divisor_reg;
    logic rx_avail_reg, tx_full_reg, thre_pend_reg;
    logic cond_err, cond_rx, cond_thre, cond_ms, int_any;
    logic [3:0] int_id;
    logic [7:0] read_value;
    logic [7:0] host_data_out_reg;
    logic host_data_oe_reg, host_int_reg, ready_reg;
    logic [EV_W-1:0] ev_status_reg, ev_enable_reg, ev_set;
    logic [15:0] sw_rdata_reg;
    logic sw_irq_reg;
    logic sw_tx_read, sw_rx_write, thre_set, thre_clr;

    // Reset pin joins the bus pins; any low of two clocks is seen
    hppc_sync #(.WIDTH(15), .RESET_VALUE(PIN_IDLE)) u_pin_sync (
        .clock(clock),
        .reset(reset),
        .async_in({reset_pin_n, device_select_n, host_rd_n, host_wr_n,
                   host_addr_bit2, host_addr_bit1, host_addr_bit0,
                   host_data_in}),
        .sync_out(pins_sync)
    );

    assign {rst_pin_n_s, sel_n_s, rd_n_s, wr_n_s, addr_s, data_s} =
        pins_sync;
    assign master_reset = reset || !rst_pin_n_s;
    assign sel_rd = !sel_n_s && !rd_n_s;
    assign sel_wr = !sel_n_s && !wr_n_s;
    assign write_commit = (state_reg == PORT_WRITE) && !sel_wr;
    assign read_done = (state_reg == PORT_READ) && !sel_rd;
    assign acc_target =
        hppc_decode(acc_addr_reg, line_ctrl_reg[LCR_DIV_ACCESS_BIT]);

    // Access sequencer; read wins if both strobes appear together
    always_ff @(posedge clock) begin
        if (master_reset) begin
            state_reg <= PORT_BOOT;
            boot_count_reg <= 32'h0000_0000;
        end else begin
            case (state_reg)
                PORT_BOOT: begin
                    boot_count_reg <= boot_count_reg + 32'h0000_0001;
                    if (boot_count_reg >= READY_CYCLES_P - 32'h0000_0001) begin
                        state_reg <= PORT_IDLE;
                    end
                end
                PORT_IDLE: begin
                    if (sel_rd) begin
                        state_reg <= PORT_READ;
                    end else if (sel_wr) begin
                        state_reg <= PORT_WRITE;
                    end
                end
                PORT_READ: begin
                    if (!sel_rd) begin
                        state_reg <= PORT_IDLE;
                    end
                end
                PORT_WRITE: begin
                    if (!sel_wr) begin
                        state_reg <= PORT_IDLE;
                    end
                end
                default: state_reg <= PORT_BOOT;
            endcase
        end
    end

    // Address and data latch as a strobe starts and follow the pins while a write strobe is held
    always_ff @(posedge clock) begin
        if (master_reset) begin
            acc_addr_reg <= 3'h0;
            wr_data_reg <= 8'h00;
        end else if (state_reg == PORT_IDLE && (sel_rd || sel_wr)) begin
            acc_addr_reg <= addr_s;
            wr_data_reg <= data_s;
        end else if (state_reg == PORT_WRITE && sel_wr) begin
            acc_addr_reg <= addr_s;
            wr_data_reg <= data_s;
        end
    end

    // Host-written configuration; divisor reloaded from store on reset
    always_ff @(posedge clock) begin
        if (master_reset) begin
            divisor_reg <= nonvolatile_store_valid ?
                nonvolatile_store_divisor : DIVISOR_DEFAULT;
            line_ctrl_reg <= LINE_CTRL_RESET;
            modem_ctrl_reg <= 5'h00;
            int_en_reg <= 4'h0;
            scratch_reg <= 8'h00;
            fifo_ctrl_reg <= 8'h00;
            tx_hold_reg <= 8'h00;
        end else if (write_commit) begin
            case (acc_target)
                T_DATA: tx_hold_reg <= wr_data_reg;
                T_DIV_LO: divisor_reg[7:0] <= wr_data_reg;
                T_DIV_HI: divisor_reg[15:8] <= wr_data_reg;
                T_INT_EN: int_en_reg <= wr_data_reg[3:0];
                T_INT_ID: fifo_ctrl_reg <= wr_data_reg;
                T_LINE_CTRL: line_ctrl_reg <= wr_data_reg;
                T_MODEM_CTRL: modem_ctrl_reg <= wr_data_reg[4:0];
                T_SCRATCH: scratch_reg <= wr_data_reg;
                default: scratch_reg <= scratch_reg;
            endcase
        end
    end

    assign sw_tx_read = sw_rd && sw_addr == SW_TX_DATA;
    assign sw_rx_write = sw_wr && sw_addr == SW_RX_DATA;

    // Receive side: set from software wins over a host read clear
    always_ff @(posedge clock) begin
        if (master_reset) begin
            rx_hold_reg <= 8'h00;
            rx_avail_reg <= 1'b0;
            rx_err_reg <= 3'h0;
        end else begin
            if (sw_rx_write) begin
                rx_hold_reg <= sw_wdata[7:0];
            end
            if (sw_rx_write) begin
                rx_avail_reg <= 1'b1;
            end else if (read_done && acc_target == T_DATA) begin
                rx_avail_reg <= 1'b0;
            end
            rx_err_reg <= ((read_done && acc_target == T_LINE_STAT) ?
                3'h0 : rx_err_reg)
                | {2'h0, sw_rx_write && rx_avail_reg}
                | ((sw_wr && sw_addr == SW_LINE_ERR) ? sw_wdata[2:0] : 3'h0);
        end
    end

    // Transmit holding and its empty flag
    assign thre_set = (sw_tx_read && tx_full_reg) ||
        (write_commit && acc_target == T_INT_EN &&
         wr_data_reg[IEN_THRE] && !int_en_reg[IEN_THRE] && !tx_full_reg);
    assign thre_clr = (write_commit && acc_target == T_DATA) ||
        (read_done && acc_target == T_INT_ID && int_id == INT_ID_THRE);

    always_ff @(posedge clock) begin
        if (master_reset) begin
            tx_full_reg <= 1'b0;
            thre_pend_reg <= 1'b1;
        end else begin
            if (write_commit && acc_target == T_DATA) begin
                tx_full_reg <= 1'b1;
            end else if (sw_tx_read) begin
                tx_full_reg <= 1'b0;
            end
            if (thre_set) begin
                thre_pend_reg <= 1'b1;
            end else if (thre_clr) begin
                thre_pend_reg <= 1'b0;
            end
        end
    end

    // Modem status changes latch until the host reads them
    always_ff @(posedge clock) begin
        if (master_reset) begin
            modem_stat_reg <= 4'h0;
            modem_delta_reg <= 4'h0;
        end else begin
            if (sw_wr && sw_addr == SW_MODEM_STAT) begin
                modem_stat_reg <= sw_wdata[3:0];
            end
            modem_delta_reg <= ((read_done && acc_target == T_MODEM_STAT) ?
                4'h0 : modem_delta_reg)
                | ((sw_wr && sw_addr == SW_MODEM_STAT) ?
                   (sw_wdata[3:0] ^ modem_stat_reg) : 4'h0);
        end
    end

    assign cond_err = int_en_reg[IEN_ERR] && |rx_err_reg;
    assign cond_rx = int_en_reg[IEN_RX] && rx_avail_reg;
    assign cond_thre = int_en_reg[IEN_THRE] && thre_pend_reg;
    assign cond_ms = int_en_reg[IEN_MS] && |modem_delta_reg;
    assign int_any = cond_err || cond_rx || cond_thre || cond_ms;

    always_comb begin
        int_id = INT_ID_NONE;
        if (cond_err) begin
            int_id = INT_ID_ERR;
        end else if (cond_rx) begin
            int_id = INT_ID_RX;
        end else if (cond_thre) begin
            int_id = INT_ID_THRE;
        end else if (cond_ms) begin
            int_id = INT_ID_MS;
        end
    end

    always_comb begin
        read_value = 8'h00;
        case (acc_target)
            T_DATA: read_value = rx_hold_reg;
            T_DIV_LO: read_value = divisor_reg[7:0];
            T_DIV_HI: read_value = divisor_reg[15:8];
            T_INT_EN: read_value = {4'h0, int_en_reg};
            T_INT_ID: read_value = {4'h0, int_id};
            T_LINE_CTRL: read_value = line_ctrl_reg;
            T_MODEM_CTRL: read_value = {3'h0, modem_ctrl_reg};
            T_LINE_STAT: begin
                read_value[LS_READY] = rx_avail_reg;
                read_value[LS_ERR_LSB +: 3] = rx_err_reg;
                read_value[LS_THR_EMPTY] = !tx_full_reg;
                read_value[LS_TX_IDLE] = !tx_full_reg;
            end
            T_MODEM_STAT: read_value = {modem_stat_reg, modem_delta_reg};
            T_SCRATCH: read_value = scratch_reg;
            default: read_value = 8'h00;
        endcase
    end

    // Host-facing outputs; bus is driven only during a selected read
    always_ff @(posedge clock) begin
        if (master_reset) begin
            host_data_out_reg <= 8'h00;
            host_data_oe_reg <= 1'b0;
            host_int_reg <= 1'b0;
            ready_reg <= 1'b0;
        end else begin
            host_data_out_reg <= read_value;
            host_data_oe_reg <= state_reg == PORT_READ && sel_rd;
            host_int_reg <= int_any;
            ready_reg <= state_reg != PORT_BOOT;
        end
    end

    // Software-side event flags; a new event beats a clear
    assign ev_set[EV_TX_WRITE] = write_commit && acc_target == T_DATA;
    assign ev_set[EV_RX_READ] = read_done && acc_target == T_DATA;
    assign ev_set[EV_CFG_WRITE] = write_commit && acc_target != T_DATA &&
        acc_target != T_SCRATCH;
    assign ev_set[EV_READY] = state_reg == PORT_BOOT &&
        boot_count_reg >= READY_CYCLES_P - 32'h0000_0001;

    always_ff @(posedge clock) begin
        if (reset) begin
            ev_status_reg <= 4'h0;
            ev_enable_reg <= 4'h0;
            sw_irq_reg <= 1'b0;
        end else begin
            ev_status_reg <= ev_set | (ev_status_reg &
                ~((sw_wr && sw_addr == SW_IRQ_CLEAR) ? sw_wdata[3:0] : 4'h0));
            if (sw_wr && sw_addr == SW_IRQ_ENABLE) begin
                ev_enable_reg <= sw_wdata[3:0];
            end
            sw_irq_reg <= |(ev_status_reg & ev_enable_reg);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            sw_rdata_reg <= 16'h0000;
        end else if (!sw_rd) begin
            sw_rdata_reg <= 16'h0000;
        end else if (sw_addr == SW_RX_DATA) begin
            sw_rdata_reg <= {15'h0000, rx_avail_reg};
        end else if (sw_addr == SW_TX_DATA) begin
            sw_rdata_reg <= {7'h00, tx_full_reg, tx_hold_reg};
        end else if (sw_addr == SW_HOST_CFG) begin
            sw_rdata_reg <= {3'h0, modem_ctrl_reg, line_ctrl_reg};
        end else if (sw_addr == SW_DIVISOR) begin
            sw_rdata_reg <= divisor_reg;
        end else if (sw_addr == SW_IRQ_STATUS) begin
            sw_rdata_reg <= {12'h000, ev_status_reg};
        end else if (sw_addr == SW_IRQ_ENABLE) begin
            sw_rdata_reg <= {12'h000, ev_enable_reg};
        end else if (sw_addr == SW_PORT_STATUS) begin
            sw_rdata_reg <= {fifo_ctrl_reg, 3'h0, host_int_reg,
                             int_id[2:0], ready_reg};
        end else begin
            sw_rdata_reg <= 16'h0000;
        end
    end

    assign host_data_out = host_data_out_reg;
    assign host_data_oe = host_data_oe_reg;
    assign host_int = host_int_reg;
    assign ready_for_commands = ready_reg;
    assign sw_rdata = sw_rdata_reg;
    assign sw_irq = sw_irq_reg;

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    chk_int_sources: assert property (
        !master_reset && int_any |=> host_int)
        else $error("interrupt missing for an enabled source");
    chk_int_reset: assert property (
        master_reset |=> !host_int && !host_data_oe)
        else $error("interrupt or bus drive survived reset");
    chk_rx_service: assert property (
        read_done && acc_target == T_DATA && !sw_rx_write
        |=> !rx_avail_reg ##1 !host_int || cond_err || cond_thre || cond_ms)
        else $error("data read did not clear receive flag");
    chk_boot_quiet: assert property (
        state_reg == PORT_BOOT |=> !host_data_oe && !tx_full_reg)
        else $error("host access acted on before ready");
    chk_ready_time: assert property (
        state_reg == PORT_BOOT && rst_pin_n_s &&
        boot_count_reg == READY_CYCLES_P - 32'h0000_0001
        |=> state_reg == PORT_IDLE ##1 ready_for_commands)
        else $error("ready not reached at the start-up count");
    chk_write_once: assert property (
        write_commit |=> !write_commit)
        else $error("one write committed twice");
    chk_oe_select: assert property (
        host_data_oe |-> $past(sel_rd) && $past(state_reg) == PORT_READ)
        else $error("bus driven without select and read strobe");
    chk_write_select: assert property (
        $rose(tx_full_reg) |-> $past(write_commit) &&
        $past(state_reg, 2) == PORT_WRITE)
        else $error("data stored without a selected write");
    chk_div_redirect: assert property (
        write_commit && acc_addr_reg == HOST_IDX_DATA &&
        line_ctrl_reg[LCR_DIV_ACCESS_BIT] && !master_reset
        |=> divisor_reg[7:0] == $past(wr_data_reg) && !$rose(tx_full_reg))
        else $error("divisor access bit did not redirect write");
    chk_read_target: assert property (
        state_reg == PORT_READ && sel_rd && !master_reset
        |=> host_data_out == $past(read_value))
        else $error("read data not from addressed register");
    chk_reload: assert property (
        master_reset |=> divisor_reg == ($past(nonvolatile_store_valid) ?
            $past(nonvolatile_store_divisor) : DIVISOR_DEFAULT))
        else $error("configuration not reloaded at reset");

    cov_host_write: cover property (write_commit && acc_target == T_DATA);
    cov_host_read: cover property (read_done && acc_target == T_LINE_STAT);
    cov_int_rise: cover property ($rose(host_int));
    cov_div_write: cover property (write_commit && acc_target == T_DIV_HI);
endmodule
`default_nettype wire

/* File: verif/hppc_host_model.sv */
// Purpose: Host processor model driving the parallel port pins
// Assumes: Pins change by non-blocking assignment after rising edges
// Notes:   Strobe held 48 ns; interaccess gap well above 10 ns
`timescale 1ns/100ps
`default_nettype none
module hppc_host_model (
    input wire logic clock,
    input wire logic host_data_oe,
    input wire logic [7:0] host_data_out,
    output logic device_select_n,
    output logic host_rd_n,
    output logic host_wr_n,
    output logic [2:0] host_addr,
    output logic [7:0] host_data_in
);
    initial begin
        {device_select_n, host_rd_n, host_wr_n} = 3'b111;
        {host_addr, host_data_in} = 11'h000;
    end

    // Returns {drive seen, data}; select and address lead the strobe
    task automatic access(input logic wr, input logic sel_n,
            input logic [2:0] idx, input logic [7:0] d,
            output logic [8:0] q);
        @(posedge clock);
        {device_select_n, host_addr, host_data_in} <= {sel_n, idx, d};
        // Four clocks so address setup covers the 15 ns minimum
        repeat (4) @(posedge clock);
        {host_rd_n, host_wr_n} <= {wr, ~wr};
        repeat (12) @(posedge clock);
        q = host_data_oe ? {1'b1, host_data_out} : 9'h000;
        {host_rd_n, host_wr_n} <= 2'b11;
        repeat (3) @(posedge clock);
        // Released bus shows inverted data, never a stale copy
        {device_select_n, host_data_in} <= {1'b1, ~d};
        repeat (4) @(posedge clock);
    endtask
endmodule
`default_nettype wire

/* File: verif/hppc_port_bench.sv */
// Purpose: Self-checking bench for the host parallel port
// Assumes: Boot delay shortened to BOOT cycles
// Notes:   Host pins come from hppc_host_model
`timescale 1ns/100ps
`default_nettype none
module hppc_port_bench;
    import hppc_pkg::*;
    localparam int BOOT = 50;
    logic clock, reset, reset_pin_n, nv_valid, sw_wr, sw_rd;
    logic sel_n, rd_n, wr_n, oe, host_int, ready, sw_irq;
    logic [2:0] addr;
    logic [7:0] din, dout;
    logic [15:0] nv_div, sw_wdata, sw_rdata, w;
    logic [3:0] sw_addr;
    logic [8:0] q;
    int err_count = 0;
    int num_checks = 0;

    hppc_port #(.READY_CYCLES_P(32'd50)) u_dut (.clock(clock),
        .reset(reset), .reset_pin_n(reset_pin_n), .device_select_n(sel_n),
        .host_rd_n(rd_n), .host_wr_n(wr_n), .host_addr_bit0(addr[0]),
        .host_addr_bit1(addr[1]), .host_addr_bit2(addr[2]),
        .host_data_in(din), .host_data_out(dout), .host_data_oe(oe),
        .host_int(host_int), .ready_for_commands(ready),
        .nonvolatile_store_valid(nv_valid),
        .nonvolatile_store_divisor(nv_div), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .sw_irq(sw_irq));
    hppc_host_model u_host (.clock(clock), .host_data_oe(oe),
        .host_data_out(dout), .device_select_n(sel_n), .host_rd_n(rd_n),
        .host_wr_n(wr_n), .host_addr(addr), .host_data_in(din));

    task automatic test_done();
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        {sw_addr, sw_wdata, sw_wr} <= {a, d, 1'b1};
        @(posedge clock);
        sw_wr <= 1'b0;
    endtask
    task automatic sw_read(input logic [3:0] a);
        @(posedge clock);
        {sw_addr, sw_rd} <= {a, 1'b1};
        @(posedge clock);
        sw_rd <= 1'b0;
        @(posedge clock);
        w = sw_rdata;
    endtask
    task automatic wait_ready();
        for (int n = 0; n < BOOT + 20 && ready !== 1'b1; n++) begin
            @(posedge clock);
        end
        chk("ready", 16'h0001, 16'(ready));
        if (ready !== 1'b1) test_done();
    endtask
    task automatic boot_check();
        u_host.access(1'b0, 1'b0, HOST_IDX_SCRATCH, 8'h00, q);
        chk("boot read", 16'h0000, 16'(q));
        chk("early ready", 16'h0000, 16'(ready));
        wait_ready();
    endtask
    task automatic map_check();
        u_host.access(1'b1, 1'b0, HOST_IDX_SCRATCH, 8'ha5, q);
        u_host.access(1'b1, 1'b1, HOST_IDX_SCRATCH, 8'h3c, q);
        u_host.access(1'b0, 1'b0, HOST_IDX_SCRATCH, 8'h00, q);
        chk("scratch", 16'h01a5, 16'(q));
        u_host.access(1'b1, 1'b0, HOST_IDX_MODEM_CTRL, 8'h15, q);
        sw_read(SW_HOST_CFG);
        chk("config", 16'h1503, w);
        sw_read(4'hf);
        chk("unmapped", 16'h0000, w);
        chk("masked irq", 16'h0000, 16'(sw_irq));
    endtask
    task automatic divisor_check();
        u_host.access(1'b1, 1'b0, HOST_IDX_LINE_CTRL, 8'h83, q);
        u_host.access(1'b1, 1'b0, HOST_IDX_DATA, 8'h34, q);
        u_host.access(1'b1, 1'b0, HOST_IDX_INT_EN, 8'h12, q);
        u_host.access(1'b1, 1'b0, HOST_IDX_LINE_CTRL, 8'h03, q);
        u_host.access(1'b0, 1'b0, HOST_IDX_INT_EN, 8'h00, q);
        chk("int enable", 16'h0100, 16'(q));
        sw_read(SW_DIVISOR);
        chk("divisor", 16'h1234, w);
    endtask
    task automatic int_check();
        u_host.access(1'b1, 1'b0, HOST_IDX_INT_EN, 8'h01, q);
        sw_write(SW_IRQ_ENABLE, 16'h0002);
        sw_write(SW_RX_DATA, 16'h005a);
        repeat (3) @(posedge clock);
        chk("int raised", 16'h0001, 16'(host_int));
        u_host.access(1'b0, 1'b0, HOST_IDX_DATA, 8'h00, q);
        chk("rx byte", 16'h015a, 16'(q));
        chk("int served", 16'h0000, 16'(host_int));
        chk("event irq", 16'h0001, 16'(sw_irq));
        sw_write(SW_IRQ_CLEAR, 16'h000f);
        repeat (2) @(posedge clock);
        chk("event clear", 16'h0000, 16'(sw_irq));
    endtask
    task automatic pin_reset_check();
        sw_write(SW_RX_DATA, 16'h0011);
        repeat (3) @(posedge clock);
        chk("int again", 16'h0001, 16'(host_int));
        {nv_valid, nv_div, reset_pin_n} <= {1'b1, 16'h0271, 1'b0};
        repeat (25000) @(posedge clock);
        chk("int reset", 16'h0000, 16'(host_int));
        chk("ready reset", 16'h0000, 16'(ready));
        reset_pin_n <= 1'b1;
        wait_ready();
        sw_read(SW_DIVISOR);
        chk("stored divisor", 16'h0271, w);
    endtask
    task automatic thre_check();
        u_host.access(1'b1, 1'b0, HOST_IDX_INT_EN, 8'h02, q);
        chk("tx empty int", 16'h0001, 16'(host_int));
        u_host.access(1'b0, 1'b0, HOST_IDX_INT_ID, 8'h00, q);
        chk("int id", 16'h0102, 16'(q));
        chk("id served", 16'h0000, 16'(host_int));
        u_host.access(1'b1, 1'b0, HOST_IDX_DATA, 8'h77, q);
        sw_read(SW_TX_DATA);
        chk("tx byte", 16'h0177, w);
        sw_write(SW_MODEM_STAT, 16'h0005);
        u_host.access(1'b0, 1'b0, HOST_IDX_MODEM_STAT, 8'h00, q);
        chk("modem status", 16'h0155, 16'(q));
        u_host.access(1'b0, 1'b0, HOST_IDX_LINE_STAT, 8'h00, q);
        chk("line status", 16'h0160, 16'(q));
        chk("int refilled", 16'h0001, 16'(host_int));
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        #300_000;
        err_count++;
        $display("CHECK FAILED run expected end seen timeout");
        test_done();
    end
    initial begin
        {reset, reset_pin_n, nv_valid, sw_wr, sw_rd} = 5'b11000;
        {nv_div, sw_wdata, sw_addr} = 36'h0_0000_0000;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        boot_check();
        map_check();
        divisor_check();
        int_check();
        pin_reset_check();
        thre_check();
        test_done();
    end
endmodule
`default_nettype wire
